// [hw/diag_alarm_pkg.sv]
// constants, field layout and carrier types for the diagnostic status and alarm block
`default_nettype none
package diag_alarm_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int VAL_W = 14;
  localparam int SRC_W = 4;
  localparam int HIST_AW = 8;
  localparam int HIST_DEPTH = 256;
  localparam int FLASH_AW = 9;
  localparam int FLASH_WORDS = 512;
  localparam int TIMER_W = 21;

  // register addresses on the register port
  localparam logic [ADDR_W-1:0] ADDR_MISC = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3c;
  localparam logic [ADDR_W-1:0] ADDR_MAG1 = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_MAG2 = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_SMPL1 = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_SMPL2 = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_CONTROL = 8'h28;

  // writable bits and reset values
  localparam logic [DATA_W-1:0] MAG_MASK = 16'hbfff;
  localparam logic [DATA_W-1:0] SMPL_MASK = 16'h00ff;
  localparam logic [DATA_W-1:0] CTRL_MASK = 16'hffd7;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // misc_control fields
  localparam int MISC_MEMTEST_BIT = 11;
  localparam int MISC_SELFTEST_BIT = 10;

  // diagnostic_status fields
  localparam int BIT_ST_Z = 15;
  localparam int BIT_ST_Y = 14;
  localparam int BIT_ST_X = 13;
  localparam int BIT_ST_GYRO = 10;
  localparam int BIT_ALM2 = 9;
  localparam int BIT_ALM1 = 8;
  localparam int BIT_CHECKSUM = 6;
  localparam int BIT_ST_DIAG = 5;
  localparam int BIT_OVERRANGE = 4;
  localparam int BIT_SERIAL = 3;
  localparam int BIT_FLASH_UPD = 2;
  localparam int BIT_SUP_HIGH = 1;
  localparam int BIT_SUP_LOW = 0;
  localparam logic [DATA_W-1:0] LEVEL_MASK = 16'h0303;

  // threshold and control fields
  localparam int MAG_DIR_BIT = 15;
  localparam int ALM1_SRC_LSB = 8;
  localparam int SRC_STRIDE = 4;
  localparam int ALM1_ROC_BIT = 6;
  localparam int CTRL_FILT_BIT = 4;
  localparam int CTRL_OUT_EN_BIT = 2;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_LINE_BIT = 0;
  localparam logic [3:0] FRAME_MOD_MASK = 4'hf;
  localparam logic [7:0] ONE_SAMPLE = 8'h01;

  // alarm source codes
  localparam logic [SRC_W-1:0] SRC_DISABLE = 4'h0;
  localparam logic [SRC_W-1:0] SRC_SUPPLY = 4'h1;
  localparam logic [SRC_W-1:0] SRC_GYRO = 4'h2;
  localparam logic [SRC_W-1:0] SRC_XACC = 4'h5;
  localparam logic [SRC_W-1:0] SRC_YACC = 4'h6;
  localparam logic [SRC_W-1:0] SRC_ZACC = 4'h7;
  localparam logic [SRC_W-1:0] SRC_TEMP = 4'h8;
  localparam logic [SRC_W-1:0] SRC_PITCH = 4'h9;
  localparam logic [SRC_W-1:0] SRC_ROLL = 4'ha;
  localparam logic [SRC_W-1:0] SRC_AUX = 4'hb;

  // timing
  localparam longint CLK_HZ = 50000000;
  localparam longint CHECKSUM_MS = 20;
  localparam longint SELFTEST_MS = 35;
  localparam int unsigned CHECKSUM_CYCLES_DEF = int'(CHECKSUM_MS * CLK_HZ / 1000);
  localparam int unsigned SELFTEST_CYCLES_DEF = int'(SELFTEST_MS * CLK_HZ / 1000);

  typedef struct packed {
    logic [VAL_W-1:0] supply;
    logic [VAL_W-1:0] gyro;
    logic [VAL_W-1:0] xacc;
    logic [VAL_W-1:0] yacc;
    logic [VAL_W-1:0] zacc;
    logic [VAL_W-1:0] temp;
    logic [VAL_W-1:0] pitch;
    logic [VAL_W-1:0] roll;
    logic [VAL_W-1:0] aux;
  } sensor_set_s;

  typedef struct packed {
    logic zacc;
    logic yacc;
    logic xacc;
    logic gyro;
    logic diag;
  } selftest_result_s;

endpackage : diag_alarm_pkg
`default_nettype wire

// [hw/flash_checksum_walk.sv]
// flash walk that sums every word and compares against the factory checksum
`default_nettype none
module flash_checksum_walk
  import diag_alarm_pkg::*;
(
  // clock and control
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  // flash read port, data one cycle after the address
  output logic [FLASH_AW-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire logic [DATA_W-1:0] factory_sum,
  // result
  output logic busy,
  output logic done,
  output logic fail
);

  typedef enum logic [2:0] {
    CK_IDLE = 3'b001,
    CK_WALK = 3'b010,
    CK_LAST = 3'b100
  } ck_state_e;

  localparam logic [FLASH_AW-1:0] LAST_ADDR = FLASH_AW'(FLASH_WORDS - 1);

  ck_state_e state_ff, nxt_state;
  logic [FLASH_AW-1:0] addr_ff;
  logic [DATA_W-1:0] sum_ff;
  logic rvalid_ff;
  logic done_ff;
  logic fail_ff;
  logic [DATA_W-1:0] nxt_sum;

  assign nxt_sum = rvalid_ff ? sum_ff + flash_rdata : sum_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CK_IDLE: if (start) nxt_state = CK_WALK;
      CK_WALK: if (addr_ff == LAST_ADDR) nxt_state = CK_LAST;
      CK_LAST: nxt_state = CK_IDLE;
      default: nxt_state = CK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CK_IDLE;
      addr_ff <= '0;
      sum_ff <= '0;
      rvalid_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      done_ff <= (state_ff == CK_LAST);
      rvalid_ff <= (state_ff == CK_WALK);
      if (state_ff == CK_IDLE) begin
        addr_ff <= '0;
        if (start) sum_ff <= '0;
      end else begin
        sum_ff <= nxt_sum;
        if (state_ff == CK_WALK && addr_ff != LAST_ADDR) addr_ff <= addr_ff + 1'b1;
      end
      if (state_ff == CK_LAST) fail_ff <= (nxt_sum != factory_sum);
    end
  end

  assign flash_addr = addr_ff;
  assign busy = (state_ff != CK_IDLE);
  assign done = done_ff;
  assign fail = fail_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_fail_matches_sum: assert property (done_ff |-> fail_ff == (sum_ff != factory_sum))
    else $error("checksum verdict disagrees with the summed flash");
  a_done_single: assert property (ce && done_ff |=> !done_ff)
    else $error("checksum done held longer than one cycle");

endmodule : flash_checksum_walk
`default_nettype wire

// [hw/diag_status_and_alarms.sv]
// diagnostic status word, checksum and self-test timing, and two-channel alarm monitor
//
// What this block does
// - memory test posts checksum result within 20 ms
// - memory test bit clears itself when done
// - status read clears all error flags
// - persisting error sets its flag next sample
// - supply flags clear when supply returns
// - self-test failures in bits 15:13, 10, 5
// - self-test results posted 35 ms after start
// - overrange bit 4, flash update bit 2
// - frame edge count not multiple of 16 flags bit 3
// - status bits 9 and 8 mirror alarms
// - two alarms evaluated independently
// - threshold: direction bit 15, value 13:0
// - sample count 7:0, zero and one mean one
// - rate window is count times sample period
// - alarm 2 source in control bits 15:12
// - alarm 1 source in bits 11:8
// - bits 7, 6 pick rate or level compare
// - control bit 4 picks filtered data
// - pitch and roll always use filtered data
// - bit 2 enable, bit 1 polarity, bit 0 line
// - alarm true when value beats threshold direction
`default_nettype none
module diag_status_and_alarms
  import diag_alarm_pkg::*;
#(
  parameter int unsigned CHECKSUM_CYCLES = CHECKSUM_CYCLES_DEF,
  parameter int unsigned SELFTEST_CYCLES = SELFTEST_CYCLES_DEF
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  // serial frame check
  input wire logic frame_end,
  input wire logic [7:0] frame_edges,
  // sensor data, one new set per sample tick
  input wire logic sample_tick,
  input wire sensor_set_s raw_data,
  input wire sensor_set_s filt_data,
  // error conditions
  input wire logic overrange,
  input wire logic flash_update_fail,
  input wire logic supply_high_pin,
  input wire logic supply_low_pin,
  input wire selftest_result_s selftest_result,
  output logic selftest_run,
  // flash read port
  output logic [FLASH_AW-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire logic [DATA_W-1:0] factory_sum,
  // alarm indicator lines
  output logic io_first_out,
  output logic io_first_oe,
  output logic io_second_out,
  output logic io_second_oe
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } selftest_state_e;

  function automatic logic [VAL_W-1:0] pick_source(input logic [SRC_W-1:0] code,
                                                   input sensor_set_s d);
    logic [VAL_W-1:0] v;
    v = '0;
    case (code)
      SRC_SUPPLY: v = d.supply;
      SRC_GYRO: v = d.gyro;
      SRC_XACC: v = d.xacc;
      SRC_YACC: v = d.yacc;
      SRC_ZACC: v = d.zacc;
      SRC_TEMP: v = d.temp;
      SRC_PITCH: v = d.pitch;
      SRC_ROLL: v = d.roll;
      SRC_AUX: v = d.aux;
      default: v = '0;
    endcase
    return v;
  endfunction : pick_source
  function automatic logic beyond(input logic [VAL_W:0] v, input logic [DATA_W-1:0] mag);
    logic signed [VAL_W:0] thr;
    logic signed [VAL_W:0] sv;
    thr = signed'({mag[VAL_W-1], mag[VAL_W-1:0]});
    sv = signed'(v);
    return mag[MAG_DIR_BIT] ? (sv > thr) : (sv < thr);
  endfunction : beyond
  // registers
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] mag_ff [2];
  logic [DATA_W-1:0] smpl_ff [2];
  logic memtest_ff;
  logic selftest_ff;
  logic [DATA_W-1:0] status_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] sup_meta_ff;
  logic [1:0] sup_sync_ff;
  selftest_state_e st_state_ff;
  logic [TIMER_W-1:0] st_cnt_ff;
  logic io_first_out_ff, io_first_oe_ff, io_second_out_ff, io_second_oe_ff;
  // decode
  wire logic tick = ce & sample_tick;
  wire logic wr_en = ce & reg_wr;
  wire logic wr_ctrl = wr_en & (reg_addr == ADDR_ALARM_CONTROL);
  wire logic wr_misc = wr_en & (reg_addr == ADDR_MISC);
  wire logic [1:0] wr_mag = {wr_en & (reg_addr == ADDR_MAG2), wr_en & (reg_addr == ADDR_MAG1)};
  wire logic [1:0] wr_smpl = {wr_en & (reg_addr == ADDR_SMPL2),
                              wr_en & (reg_addr == ADDR_SMPL1)};
  wire logic rd_clr = ce & reg_rd & (reg_addr == ADDR_STATUS);
  // self-test timing
  wire logic st_start = wr_misc & reg_wdata[MISC_SELFTEST_BIT] & (st_state_ff == ST_IDLE);
  wire logic st_post = ce & (st_state_ff == ST_RUN) &
                       (st_cnt_ff == TIMER_W'(SELFTEST_CYCLES - 1));
  // checksum walk
  wire logic chk_start = wr_misc & reg_wdata[MISC_MEMTEST_BIT] & !memtest_ff;
  logic chk_busy, chk_done, chk_fail;
  flash_checksum_walk u_walk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(chk_start),
    .flash_addr(flash_addr),
    .flash_rdata(flash_rdata),
    .factory_sum(factory_sum),
    .busy(chk_busy),
    .done(chk_done),
    .fail(chk_fail)
  );
  // alarm channels
  logic [1:0] hit;
  logic [1:0] alarm_vec;
  for (genvar k = 0; k < 2; k++) begin : g_alm
    logic [SRC_W-1:0] code;
    logic rate_of_change, use_filt;
    logic [VAL_W-1:0] cur, old;
    logic [7:0] win;
    logic [VAL_W:0] diff, cmpv;
    logic [VAL_W-1:0] hist_ff [HIST_DEPTH];
    logic [HIST_AW-1:0] ptr_ff;
    logic [HIST_AW-1:0] fill_ff;
    logic alarm_ff;

    assign code = ctrl_ff[ALM1_SRC_LSB + k * SRC_STRIDE +: SRC_W];
    assign rate_of_change = ctrl_ff[ALM1_ROC_BIT + k];
    assign use_filt = ctrl_ff[CTRL_FILT_BIT] | (code == SRC_PITCH) | (code == SRC_ROLL);
    assign cur = pick_source(code, use_filt ? filt_data : raw_data);
    assign win = (smpl_ff[k][7:0] <= ONE_SAMPLE) ? ONE_SAMPLE : smpl_ff[k][7:0];
    assign old = hist_ff[ptr_ff - win];
    assign diff = {cur[VAL_W-1], cur} - {old[VAL_W-1], old};
    assign cmpv = rate_of_change ? diff : {cur[VAL_W-1], cur};
    assign hit[k] = (code != SRC_DISABLE) & (!rate_of_change | (fill_ff >= win)) &
                    beyond(cmpv, mag_ff[k]);
    assign alarm_vec[k] = alarm_ff;

    // history holds data only, so it carries no reset
    always_ff @(posedge sys_clk) begin
      if (tick) hist_ff[ptr_ff] <= cur;
    end
    // a control write restarts the fill so a new source never compares against old data
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_ff <= '0;
        fill_ff <= '0;
        alarm_ff <= 1'b0;
      end else if (ce) begin
        if (tick) begin
          ptr_ff <= ptr_ff + 1'b1;
          alarm_ff <= hit[k];
        end
        if (wr_ctrl) fill_ff <= '0;
        else if (tick && !(&fill_ff)) fill_ff <= fill_ff + 1'b1;
      end
    end
  end
  // status composition
  wire logic [DATA_W-1:0] set_vec =
    (DATA_W'(st_post & selftest_result.zacc) << BIT_ST_Z) |
    (DATA_W'(st_post & selftest_result.yacc) << BIT_ST_Y) |
    (DATA_W'(st_post & selftest_result.xacc) << BIT_ST_X) |
    (DATA_W'(st_post & selftest_result.gyro) << BIT_ST_GYRO) |
    (DATA_W'(st_post & selftest_result.diag) << BIT_ST_DIAG) |
    (DATA_W'(ce & chk_done & chk_fail) << BIT_CHECKSUM) |
    (DATA_W'(tick & overrange) << BIT_OVERRANGE) |
    (DATA_W'(ce & flash_update_fail) << BIT_FLASH_UPD) |
    (DATA_W'(ce & frame_end & ((frame_edges[3:0] & FRAME_MOD_MASK) != 4'h0))
      << BIT_SERIAL);
  wire logic [DATA_W-1:0] lv_tick = (DATA_W'(hit) << BIT_ALM1) | DATA_W'(sup_sync_ff);
  wire logic [DATA_W-1:0] lv_hold = (DATA_W'(alarm_vec) << BIT_ALM1) | DATA_W'(sup_sync_ff);
  wire logic [DATA_W-1:0] clr_vec = rd_clr ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
  wire logic [DATA_W-1:0] sticky = (status_ff & ~LEVEL_MASK & ~clr_vec) | set_vec;
  wire logic [DATA_W-1:0] level = tick ? lv_tick : (status_ff & lv_hold & ~clr_vec);
  wire logic [DATA_W-1:0] nxt_status = (sticky & ~LEVEL_MASK) | (level & LEVEL_MASK);
  // read mux
  wire logic [DATA_W-1:0] misc_rd = (DATA_W'(memtest_ff) << MISC_MEMTEST_BIT) |
                                    (DATA_W'(selftest_ff) << MISC_SELFTEST_BIT);
  wire logic [DATA_W-1:0] nxt_rdata =
    (reg_addr == ADDR_STATUS) ? status_ff :
    (reg_addr == ADDR_ALARM_CONTROL) ? ctrl_ff :
    (reg_addr == ADDR_MAG1) ? mag_ff[0] :
    (reg_addr == ADDR_MAG2) ? mag_ff[1] :
    (reg_addr == ADDR_SMPL1) ? smpl_ff[0] :
    (reg_addr == ADDR_SMPL2) ? smpl_ff[1] :
    (reg_addr == ADDR_MISC) ? misc_rd : REG_RESET;
  // indicator lines
  wire logic alarm_any = |alarm_vec;
  wire logic out_en = ctrl_ff[CTRL_OUT_EN_BIT];
  wire logic out_lvl = ctrl_ff[CTRL_POL_BIT] ? alarm_any : !alarm_any;
  wire logic nxt_first_oe = out_en & !ctrl_ff[CTRL_LINE_BIT];
  wire logic nxt_second_oe = out_en & ctrl_ff[CTRL_LINE_BIT];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= REG_RESET;
      mag_ff <= '{REG_RESET, REG_RESET};
      smpl_ff <= '{REG_RESET, REG_RESET};
      status_ff <= REG_RESET;
      rdata_ff <= REG_RESET;
      sup_meta_ff <= '0;
      sup_sync_ff <= '0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_ff <= reg_wdata & CTRL_MASK;
      for (int i = 0; i < 2; i++) begin
        if (wr_mag[i]) mag_ff[i] <= reg_wdata & MAG_MASK;
        if (wr_smpl[i]) smpl_ff[i] <= reg_wdata & SMPL_MASK;
      end
      status_ff <= nxt_status;
      if (reg_rd) rdata_ff <= nxt_rdata;
      sup_meta_ff <= {supply_high_pin, supply_low_pin};
      sup_sync_ff <= sup_meta_ff;
    end
  end
  // a new start while a test runs is ignored; the running test keeps its bit set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      memtest_ff <= 1'b0;
      selftest_ff <= 1'b0;
      st_state_ff <= ST_IDLE;
      st_cnt_ff <= '0;
    end else if (ce) begin
      if (chk_start) memtest_ff <= 1'b1;
      else if (chk_done) memtest_ff <= 1'b0;
      unique case (st_state_ff)
        ST_IDLE: begin
          st_cnt_ff <= '0;
          if (st_start) begin
            st_state_ff <= ST_RUN;
            selftest_ff <= 1'b1;
          end
        end
        ST_RUN: begin
          st_cnt_ff <= st_cnt_ff + 1'b1;
          if (st_post) begin
            st_state_ff <= ST_IDLE;
            selftest_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_first_out_ff <= 1'b0;
      io_first_oe_ff <= 1'b0;
      io_second_out_ff <= 1'b0;
      io_second_oe_ff <= 1'b0;
    end else if (ce) begin
      io_first_oe_ff <= nxt_first_oe;
      io_second_oe_ff <= nxt_second_oe;
      io_first_out_ff <= nxt_first_oe & out_lvl;
      io_second_out_ff <= nxt_second_oe & out_lvl;
    end
  end

  assign reg_rdata = rdata_ff;
  assign selftest_run = selftest_ff;
  assign io_first_out = io_first_out_ff;
  assign io_first_oe = io_first_oe_ff;
  assign io_second_out = io_second_out_ff;
  assign io_second_oe = io_second_oe_ff;
  // checking helpers: age of a pending memory test
  logic [TIMER_W-1:0] chk_age_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) chk_age_ff <= '0;
    else if (ce) chk_age_ff <= memtest_ff ? chk_age_ff + 1'b1 : '0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_chk_finish;
    chk_done ##1 !memtest_ff;
  endsequence
  sequence s_st_finish;
    st_post ##1 (st_state_ff == ST_IDLE && !selftest_ff);
  endsequence
  a_checksum_bound: assert property (chk_age_ff < TIMER_W'(CHECKSUM_CYCLES))
    else $error("checksum result not posted in time");
  a_memtest_self_clear: assert property (ce && chk_done && !chk_start |-> s_chk_finish)
    else $error("memory test bit did not clear after the walk");
  a_status_read_clear: assert property (rd_clr && !tick && set_vec == '0 |=> status_ff == '0)
    else $error("status read did not clear the flags");
  a_overrange_return: assert property (tick && overrange |=> status_ff[BIT_OVERRANGE])
    else $error("persisting overrange did not set its flag");
  a_supply_auto_clear: assert property (ce && !tick && !sup_sync_ff[0] |=>
      !status_ff[BIT_SUP_LOW])
    else $error("low supply flag stayed set with supply in range");
  a_selftest_post: assert property (ce && st_post |-> s_st_finish)
    else $error("self-test did not finish on its post cycle");
  a_selftest_gyro: assert property (st_post && selftest_result.gyro |=>
      status_ff[BIT_ST_GYRO])
    else $error("gyro self-test failure not reported");
  a_frame_error: assert property (ce && frame_end && frame_edges[3:0] != 4'h0 |=>
      status_ff[BIT_SERIAL])
    else $error("bad frame length not flagged");
  a_alarm_mirror: assert property (tick |=> status_ff[BIT_ALM2:BIT_ALM1] == alarm_vec)
    else $error("status alarm bits do not follow the alarms");
  a_disable_quiet: assert property (tick && g_alm[0].code == SRC_DISABLE |=> !alarm_vec[0])
    else $error("disabled alarm became active");
  a_first_line_level: assert property (ce && nxt_first_oe |=> io_first_oe_ff &&
      io_first_out_ff == ($past(ctrl_ff[CTRL_POL_BIT]) == $past(alarm_any)))
    else $error("first indicator line has the wrong level");

endmodule : diag_status_and_alarms
`default_nettype wire

// [tb/flash_rom_model.sv]
// flash array model for the checksum walk: each word holds its own address
`default_nettype none
module flash_rom_model
  import diag_alarm_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // flash read port
  input wire logic [FLASH_AW-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // data lags the address by one edge, never sooner, as the real array does
  always_ff @(posedge sys_clk) begin
    flash_rdata <= {7'h00, flash_addr};
  end
endmodule : flash_rom_model
`default_nettype wire

// [tb/diag_status_and_alarms_test.sv]
// self-checking bench for the diagnostic status and alarm block
`default_nettype none
module diag_status_and_alarms_test
  import diag_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CK = 600;
  localparam int unsigned ST = 50;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic [DATA_W-1:0] reg_rdata;
  logic frame_end = 1'b0;
  logic [7:0] frame_edges = 8'h00;
  logic sample_tick = 1'b0;
  sensor_set_s raw_data = '0;
  sensor_set_s filt_data = '0;
  logic overrange = 1'b0;
  logic flash_update_fail = 1'b0;
  logic supply_low_pin = 1'b0;
  logic supply_high_pin = 1'b0;
  logic ce = 1'b1;
  selftest_result_s selftest_result = 5'h1a;
  logic selftest_run;
  logic [FLASH_AW-1:0] flash_addr;
  logic [DATA_W-1:0] flash_rdata;
  logic [DATA_W-1:0] factory_sum = 16'h1234;
  logic io_first_out;
  logic io_first_oe;
  logic io_second_out;
  logic io_second_oe;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #10 sys_clk = ~sys_clk;

  diag_status_and_alarms #(.CHECKSUM_CYCLES(CK), .SELFTEST_CYCLES(ST)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_end(frame_end), .frame_edges(frame_edges),
    .sample_tick(sample_tick), .raw_data(raw_data), .filt_data(filt_data),
    .overrange(overrange), .flash_update_fail(flash_update_fail),
    .supply_high_pin(supply_high_pin), .supply_low_pin(supply_low_pin),
    .selftest_result(selftest_result), .selftest_run(selftest_run),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .factory_sum(factory_sum),
    .io_first_out(io_first_out), .io_first_oe(io_first_oe),
    .io_second_out(io_second_out), .io_second_oe(io_second_oe)
  );

  flash_rom_model flash (
    .sys_clk(sys_clk), .flash_addr(flash_addr), .flash_rdata(flash_rdata)
  );

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // strobes drop after the taking edge and stay low one cycle, so calls chain safely
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    chk(reg_rdata, exp);
  endtask : rd

  task automatic tick();
    sample_tick = 1'b1;
    step(1);
    sample_tick = 1'b0;
    step(1);
  endtask : tick

  task automatic frame(input logic [7:0] n);
    frame_edges = n;
    frame_end = 1'b1;
    step(1);
    frame_end = 1'b0;
    step(1);
  endtask : frame

  function automatic logic [DATA_W-1:0] lines();
    return {12'h000, io_first_oe, io_first_out, io_second_oe, io_second_out};
  endfunction : lines

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    step(10);
    rst_n = 1'b1;
    step(1);
    rd(ADDR_STATUS, 16'h0000);
    rd(ADDR_ALARM_CONTROL, 16'h0000);
    chk(lines(), 16'h0000);
    wr(ADDR_MAG1, 16'hffff);
    rd(ADDR_MAG1, 16'hbfff);
    wr(ADDR_SMPL1, 16'hffff);
    rd(ADDR_SMPL1, 16'h00ff);
    wr(ADDR_ALARM_CONTROL, 16'hffff);
    rd(ADDR_ALARM_CONTROL, 16'hffd7);
    wr(ADDR_ALARM_CONTROL, 16'h0000);
    rd(8'h10, 16'h0000);
    // a write strobed while the enable is low must leave the register alone
    ce = 1'b0;
    wr(ADDR_MAG1, 16'h0001);
    ce = 1'b1;
    rd(ADDR_MAG1, 16'hbfff);
    frame(8'd32);
    rd(ADDR_STATUS, 16'h0000);
    frame(8'd17);
    rd(ADDR_STATUS, 16'h0008);
    rd(ADDR_STATUS, 16'h0000);
    overrange = 1'b1;
    tick();
    rd(ADDR_STATUS, 16'h0010);
    tick();
    rd(ADDR_STATUS, 16'h0010);
    overrange = 1'b0;
    tick();
    rd(ADDR_STATUS, 16'h0000);
    flash_update_fail = 1'b1;
    step(1);
    flash_update_fail = 1'b0;
    rd(ADDR_STATUS, 16'h0004);
    supply_low_pin = 1'b1;
    supply_high_pin = 1'b1;
    step(4);
    tick();
    rd(ADDR_STATUS, 16'h0003);
    tick();
    supply_low_pin = 1'b0;
    supply_high_pin = 1'b0;
    step(4);
    rd(ADDR_STATUS, 16'h0000);
    // sum of words 0..511 is 16'hff00, so 16'h1234 must fail
    wr(ADDR_MISC, 16'h0800);
    step(CK);
    rd(ADDR_STATUS, 16'h0040);
    rd(ADDR_MISC, 16'h0000);
    factory_sum = 16'hff00;
    wr(ADDR_MISC, 16'h0800);
    step(CK);
    rd(ADDR_STATUS, 16'h0000);
    wr(ADDR_MISC, 16'h0400);
    chk({15'h0000, selftest_run}, 16'h0001);
    step(ST + 4);
    rd(ADDR_STATUS, 16'hc400);
    rd(ADDR_MISC, 16'h0000);
    // alarm 1 on x accel above 256, second line, active high; alarm 2 disabled
    wr(ADDR_MAG2, 16'h8000);
    wr(ADDR_MAG1, 16'h8100);
    wr(ADDR_ALARM_CONTROL, 16'h0507);
    raw_data.xacc = 14'd300;
    tick();
    step(1);
    chk(lines(), 16'h0003);
    rd(ADDR_STATUS, 16'h0100);
    raw_data.xacc = 14'd0;
    tick();
    step(1);
    chk(lines(), 16'h0002);
    wr(ADDR_ALARM_CONTROL, 16'h0504);
    step(1);
    chk(lines(), 16'h000c);
    // rate mode over two samples: a step of 100 beats 50 on two ticks, then clears
    wr(ADDR_SMPL1, 16'h0002);
    wr(ADDR_MAG1, 16'h8032);
    wr(ADDR_ALARM_CONTROL, 16'h0547);
    repeat (3) tick();
    raw_data.xacc = 14'd100;
    tick();
    step(1);
    chk(lines(), 16'h0003);
    tick();
    tick();
    step(1);
    chk(lines(), 16'h0002);
    // alarm 2 alone on pitch above 0: raw pitch is 0, only filtered data can trip it
    filt_data.pitch = 14'd300;
    filt_data.xacc = 14'd300;
    wr(ADDR_MAG1, 16'h8100);
    wr(ADDR_ALARM_CONTROL, 16'h9007);
    tick();
    step(1);
    chk(lines(), 16'h0003);
    rd(ADDR_STATUS, 16'h0200);
    wr(ADDR_ALARM_CONTROL, 16'h0507);
    tick();
    step(1);
    chk(lines(), 16'h0002);
    wr(ADDR_ALARM_CONTROL, 16'h0517);
    tick();
    step(1);
    chk(lines(), 16'h0003);
    give_verdict();
  end
endmodule : diag_status_and_alarms_test
`default_nettype wire
